// File: core/pspg_top.sv
// Serial register port with protocol detection and shared output pin control
// Summary of operation
// - Register 0 read returns the fixed version code; no oscillator version exists.
// - After reset the pin driver is off, driving only during addressed reads.
// - Legacy protocol drives the pin only in last 24 bits of reads.
// - Multi-target protocol drives when the last three bits equal chip address zero.
// - Frame select rising before any nonzero address bit still drives the line.
// - Output-enable hold bit keeps the driver permanently on.
// - Reads route read data to pin unless source-hold bit is set.
// - Chip-gate bit cleared lets the driver work while the chip is disabled.
// - Master driver bit cleared disables the driver above all else.
// - Two bits separately disable the pull-up and pull-down halves.
// - Multi-target read spans first clock rise to next frame select rise.
// - Five-bit selector picks the general signal; default one is lock detect.
// - First frame select rise picks legacy, first clock rise multi-target; sticky.
// - Register 0 reads version; its write in either protocol holds read address, soft reset, strobes.
// - Legacy direction bit sampled at first clock rise; low means write.
// - Legacy six address bits captured MSB first on rises two to seven.
// - Legacy write data shifts on rises 8 to 31, commits at rise 32.
// - Legacy high direction bit at the first rise starts a read.
// - Legacy read drives 24 data bits MSB first on rises 8 to 31.
// - Legacy read restores lock detect at rise 32; frame select drop ends frame.
// - Multi-target frame is data, register address, chip address; latched at select rise.
// - Multi-target frames output the register chosen by the last read address write.
// - Soft reset leaves the chosen protocol unchanged.
`timescale 1ns/100ps
module pspg_top #(
	parameter logic [23:0] VERSION_CODE = 24'hA5C301 // Arbitrary value
) (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic SCK_PIN,
	input wire logic FRAME_SELECT,
	input wire logic SDI_PIN,
	input wire logic CHIP_EN,
	input wire logic [31:0] GENERAL_OUTPUT_SOURCES,
	output logic LOCK_DETECT_SERIAL_OUT_PIN_O,
	output logic LOCK_DETECT_SERIAL_OUT_PIN_OE_N,
	output logic [1:0] PROTOCOL_MODE,
	output logic REG_WR_PULSE,
	output logic [5:0] REG_WR_ADDR,
	output logic [23:0] REG_WR_DATA,
	output logic [17:0] GEN_STROBES
);
	logic sck_lvl, sck_rise, sen_lvl, sen_rise, sdi_lvl, chip_en_lvl;

	pspg_sync u_sck (
		.clk(CORE_CLK),
		.srst(SRST),
		.din(SCK_PIN),
		.level(sck_lvl),
		.rise(sck_rise),
		.fall()
	);

	pspg_sync u_sen (
		.clk(CORE_CLK),
		.srst(SRST),
		.din(FRAME_SELECT),
		.level(sen_lvl),
		.rise(sen_rise),
		.fall()
	);

	pspg_sync u_sdi (
		.clk(CORE_CLK),
		.srst(SRST),
		.din(SDI_PIN),
		.level(sdi_lvl),
		.rise(),
		.fall()
	);

	pspg_sync u_cen (
		.clk(CORE_CLK),
		.srst(SRST),
		.din(CHIP_EN),
		.level(chip_en_lvl),
		.rise(),
		.fall()
	);

	pspg_pkg::pspg_mode_t mode_ff, nxt_mode, mode_now;
	logic [5:0] lg_cnt_ff, nxt_lg_cnt, cnt_n;
	logic lg_rd_ff, nxt_lg_rd;
	logic [5:0] lg_addr_ff, nxt_lg_addr;
	logic [23:0] lg_data_ff, nxt_lg_data;
	logic [31:0] mt_sr_ff, nxt_mt_sr;
	logic [5:0] mt_cnt_ff, nxt_mt_cnt;
	logic mt_act_ff, nxt_mt_act;
	logic [23:0] rd_sr_ff, nxt_rd_sr;
	logic [4:0] rd_addr_ff, nxt_rd_addr;
	logic wr_ff, nxt_wr;
	logic [5:0] wr_addr_ff, nxt_wr_addr;
	logic [23:0] wr_data_ff, nxt_wr_data;
	logic [17:0] strobe_ff, nxt_strobe;
	logic soft_rst;
	logic [23:0] reg_mem_ff [0:63];
	logic lg_read_active, mt_read_active, read_active;
	logic [23:0] pin_cfg, drv_ctrl, chip_ctrl;

	// Register 0 is never stored; its read value is the version code
	function automatic logic [23:0] reg_rd(input logic [5:0] a);
		if (a == pspg_pkg::REG_VERSION) begin
			return VERSION_CODE;
		end
		return reg_mem_ff[a];
	endfunction : reg_rd

	function automatic logic [23:0] reg_default(input logic [5:0] a);
		case (a)
			pspg_pkg::REG_CHIP_CTRL: return pspg_pkg::RST_CHIP_CTRL;
			pspg_pkg::REG_DRV_CTRL: return pspg_pkg::RST_DRV_CTRL;
			pspg_pkg::REG_PIN_CFG: return pspg_pkg::RST_PIN_CFG;
			default: return pspg_pkg::RST_OTHER;
		endcase
	endfunction : reg_default

	always_comb begin
		nxt_lg_cnt = lg_cnt_ff;
		nxt_lg_rd = lg_rd_ff;
		nxt_lg_addr = lg_addr_ff;
		nxt_lg_data = lg_data_ff;
		nxt_mt_sr = mt_sr_ff;
		nxt_mt_cnt = mt_cnt_ff;
		nxt_mt_act = mt_act_ff;
		nxt_rd_sr = rd_sr_ff;
		nxt_rd_addr = rd_addr_ff;
		nxt_wr = 1'b0;
		nxt_wr_addr = wr_addr_ff;
		nxt_wr_data = wr_data_ff;
		nxt_strobe = 18'h00000;
		soft_rst = 1'b0;
		cnt_n = 6'h00;
		mode_now = mode_ff;
		// Frame select wins a tie, since its edge also opens a legacy frame
		if (mode_ff == pspg_pkg::PSPG_UNDECIDED) begin
			if (sen_rise) begin
				mode_now = pspg_pkg::PSPG_LEGACY;
			end else if (sck_rise) begin
				mode_now = pspg_pkg::PSPG_MULTI;
			end
		end
		nxt_mode = mode_now;
		case (mode_now)
			pspg_pkg::PSPG_LEGACY: begin
				if (sen_rise) begin
					nxt_lg_cnt = 6'h00;
					nxt_lg_rd = 1'b0;
				end else if (sen_lvl && sck_rise && lg_cnt_ff < pspg_pkg::LG_COMMIT) begin
					cnt_n = lg_cnt_ff + 6'h01;
					nxt_lg_cnt = cnt_n;
					if (cnt_n == pspg_pkg::LG_RW_EDGE) begin
						nxt_lg_rd = sdi_lvl;
					end else if (cnt_n <= pspg_pkg::LG_ADDR_LAST) begin
						nxt_lg_addr = {lg_addr_ff[4:0], sdi_lvl};
					end else if (cnt_n <= pspg_pkg::LG_DATA_LAST) begin
						nxt_lg_data = {lg_data_ff[22:0], sdi_lvl};
					end
					if (lg_rd_ff && cnt_n == pspg_pkg::LG_DATA_FIRST) begin
						nxt_rd_sr = reg_rd(lg_addr_ff);
					end else if (lg_rd_ff) begin
						nxt_rd_sr = {rd_sr_ff[22:0], 1'b0};
					end
					if (!lg_rd_ff && cnt_n == pspg_pkg::LG_COMMIT) begin
						nxt_wr = 1'b1;
						nxt_wr_addr = lg_addr_ff;
						nxt_wr_data = lg_data_ff;
					end
				end
			end
			pspg_pkg::PSPG_MULTI: begin
				if (sen_rise) begin
					// Short or foreign frames are dropped without effect
					if (mt_cnt_ff == pspg_pkg::MT_FRAME_BITS
						&& mt_sr_ff[2:0] == pspg_pkg::MT_CHIP_SELF) begin
						nxt_wr = 1'b1;
						nxt_wr_addr = {1'b0, mt_sr_ff[7:3]};
						nxt_wr_data = mt_sr_ff[31:8];
					end
					nxt_mt_act = 1'b0;
					nxt_mt_cnt = 6'h00;
					nxt_mt_sr = 32'h00000000;
				end else if (sck_rise && !sen_lvl) begin
					nxt_mt_sr = {mt_sr_ff[30:0], sdi_lvl};
					if (mt_cnt_ff < pspg_pkg::MT_FRAME_BITS) begin
						nxt_mt_cnt = mt_cnt_ff + 6'h01;
					end
					if (!mt_act_ff) begin
						nxt_mt_act = 1'b1;
						nxt_rd_sr = reg_rd({1'b0, rd_addr_ff});
					end else begin
						nxt_rd_sr = {rd_sr_ff[22:0], 1'b0};
					end
				end
			end
			default: nxt_mode = mode_now;
		endcase
		if (nxt_wr && nxt_wr_addr == pspg_pkg::REG_VERSION) begin
			soft_rst = nxt_wr_data[pspg_pkg::SOFT_RST_BIT];
			nxt_rd_addr = nxt_wr_data[pspg_pkg::RD_ADDR_MSB:pspg_pkg::RD_ADDR_LSB];
			nxt_strobe = nxt_wr_data[pspg_pkg::STROBE_MSB:pspg_pkg::STROBE_LSB];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			mode_ff <= pspg_pkg::PSPG_UNDECIDED;
			lg_cnt_ff <= 6'h00;
			lg_rd_ff <= 1'b0;
			lg_addr_ff <= 6'h00;
			lg_data_ff <= 24'h000000;
			mt_sr_ff <= 32'h00000000;
			mt_cnt_ff <= 6'h00;
			mt_act_ff <= 1'b0;
			rd_sr_ff <= 24'h000000;
			rd_addr_ff <= 5'h00;
			wr_ff <= 1'b0;
			wr_addr_ff <= 6'h00;
			wr_data_ff <= 24'h000000;
			strobe_ff <= 18'h00000;
		end else begin
			mode_ff <= nxt_mode;
			lg_cnt_ff <= nxt_lg_cnt;
			lg_rd_ff <= nxt_lg_rd;
			lg_addr_ff <= nxt_lg_addr;
			lg_data_ff <= nxt_lg_data;
			mt_sr_ff <= nxt_mt_sr;
			mt_cnt_ff <= nxt_mt_cnt;
			mt_act_ff <= nxt_mt_act;
			rd_sr_ff <= nxt_rd_sr;
			rd_addr_ff <= nxt_rd_addr;
			wr_ff <= nxt_wr;
			wr_addr_ff <= nxt_wr_addr;
			wr_data_ff <= nxt_wr_data;
			strobe_ff <= nxt_strobe;
		end
	end

	// Soft reset restores the register file but not the chosen protocol
	always_ff @(posedge CORE_CLK) begin
		if (SRST || soft_rst) begin
			for (int i = 0; i < 64; i++) begin
				reg_mem_ff[i] <= reg_default(6'(i));
			end
		end else if (nxt_wr && nxt_wr_addr != pspg_pkg::REG_VERSION) begin
			reg_mem_ff[nxt_wr_addr] <= nxt_wr_data;
		end
	end

	assign pin_cfg = reg_mem_ff[pspg_pkg::REG_PIN_CFG];
	assign drv_ctrl = reg_mem_ff[pspg_pkg::REG_DRV_CTRL];
	assign chip_ctrl = reg_mem_ff[pspg_pkg::REG_CHIP_CTRL];

	// Legacy drive ends at rise 32, when the count leaves the data window
	assign lg_read_active = mode_ff == pspg_pkg::PSPG_LEGACY && sen_lvl && lg_rd_ff
		&& lg_cnt_ff >= pspg_pkg::LG_DATA_FIRST
		&& lg_cnt_ff <= pspg_pkg::LG_DATA_LAST;
	// Zeros shifted in so far never disqualify, so early select still drives
	assign mt_read_active = mode_ff == pspg_pkg::PSPG_MULTI && mt_act_ff
		&& mt_sr_ff[2:0] == pspg_pkg::MT_CHIP_SELF;
	assign read_active = lg_read_active
		|| (mode_ff == pspg_pkg::PSPG_MULTI && mt_act_ff);

	pspg_pin_drv u_drv (
		.clk(CORE_CLK),
		.srst(SRST),
		.read_active(read_active),
		.read_drive(lg_read_active || mt_read_active),
		.read_bit(rd_sr_ff[23]),
		.gpo_bit(GENERAL_OUTPUT_SOURCES[pin_cfg[pspg_pkg::SEL_MSB:pspg_pkg::SEL_LSB]]),
		.master_en(drv_ctrl[pspg_pkg::DRV_MASTER_BIT]),
		.oe_hold(pin_cfg[pspg_pkg::OE_HOLD_BIT]),
		.src_hold(pin_cfg[pspg_pkg::SRC_HOLD_BIT]),
		.chip_gate(chip_ctrl[pspg_pkg::CHIP_GATE_BIT]),
		.chip_en(chip_en_lvl),
		.up_off(pin_cfg[pspg_pkg::UP_OFF_BIT]),
		.dn_off(pin_cfg[pspg_pkg::DN_OFF_BIT]),
		.pin_out(LOCK_DETECT_SERIAL_OUT_PIN_O),
		.pin_oe_n(LOCK_DETECT_SERIAL_OUT_PIN_OE_N)
	);

	assign PROTOCOL_MODE = mode_ff;
	assign REG_WR_PULSE = wr_ff;
	assign REG_WR_ADDR = wr_addr_ff;
	assign REG_WR_DATA = wr_data_ff;
	assign GEN_STROBES = strobe_ff;

	mode_sticky_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		mode_ff != pspg_pkg::PSPG_UNDECIDED |=> mode_ff == $past(mode_ff))
		else $error("protocol changed after decision");
	legacy_pick_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_UNDECIDED && sen_rise)
		|=> mode_ff == pspg_pkg::PSPG_LEGACY) else $error("legacy not selected");
	multi_pick_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_UNDECIDED && !sen_rise && sck_rise)
		|=> mode_ff == pspg_pkg::PSPG_MULTI) else $error("multi-target not selected");
	lg_commit_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_LEGACY && !sen_rise && sen_lvl && sck_rise && !lg_rd_ff
		&& lg_cnt_ff == 6'h1F) |=> wr_ff && wr_addr_ff == $past(lg_addr_ff)
		&& wr_data_ff == $past(lg_data_ff)) else $error("legacy write not committed");
	lg_read_nowr_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(wr_ff && mode_ff == pspg_pkg::PSPG_LEGACY) |-> !$past(lg_rd_ff))
		else $error("legacy read frame wrote a register");
	lg_window_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(lg_read_active && sck_rise && lg_cnt_ff == 6'h1F && !sen_rise)
		|=> !lg_read_active) else $error("legacy read drive past rise 32");
	version_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_LEGACY && !sen_rise && sen_lvl && sck_rise && lg_rd_ff
		&& lg_cnt_ff == 6'h07 && lg_addr_ff == 6'h00) |=> rd_sr_ff == VERSION_CODE)
		else $error("version code not loaded");
	mt_latch_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_MULTI && sen_rise && mt_cnt_ff == 6'h20
		&& mt_sr_ff[2:0] == 3'h0) |=> wr_ff && wr_data_ff == $past(mt_sr_ff[31:8]))
		else $error("multi-target frame not latched");
	mt_foreign_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_MULTI && sen_rise && mt_sr_ff[2:0] != 3'h0)
		|=> !wr_ff) else $error("foreign chip address accepted");
	mt_end_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		(mode_ff == pspg_pkg::PSPG_MULTI && sen_rise) |=> !mt_act_ff ##1 !read_active)
		else $error("read portion outlived frame select rise");
	soft_keep_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		soft_rst |=> mode_ff == $past(mode_ff) && rd_addr_ff == $past(nxt_rd_addr)
		&& pin_cfg == pspg_pkg::RST_PIN_CFG)
		else $error("soft reset disturbed protocol");
endmodule : pspg_top

// File: pkg/pspg_pkg.sv
// Shared constants and types for the serial port and shared output pin block
package pspg_pkg;

	typedef enum logic [1:0] {
		PSPG_UNDECIDED = 2'b00,
		PSPG_LEGACY = 2'b01,
		PSPG_MULTI = 2'b10
	} pspg_mode_t;

	// Register addresses
	localparam logic [5:0] REG_VERSION = 6'h00;
	localparam logic [5:0] REG_CHIP_CTRL = 6'h01;
	localparam logic [5:0] REG_DRV_CTRL = 6'h08;
	localparam logic [5:0] REG_PIN_CFG = 6'h0F;

	// Field positions
	localparam int CHIP_GATE_BIT = 7;
	localparam int DRV_MASTER_BIT = 5;
	localparam int SEL_LSB = 0;
	localparam int SEL_MSB = 4;
	localparam int SRC_HOLD_BIT = 6;
	localparam int OE_HOLD_BIT = 7;
	localparam int UP_OFF_BIT = 8;
	localparam int DN_OFF_BIT = 9;
	localparam int RD_ADDR_LSB = 0;
	localparam int RD_ADDR_MSB = 4;
	localparam int SOFT_RST_BIT = 5;
	localparam int STROBE_LSB = 6;
	localparam int STROBE_MSB = 23;

	// Reset values
	localparam logic [23:0] RST_CHIP_CTRL = 24'h000080;
	localparam logic [23:0] RST_DRV_CTRL = 24'h000020;
	localparam logic [23:0] RST_PIN_CFG = 24'h000001;
	localparam logic [23:0] RST_OTHER = 24'h000000;

	// Serial clock edge counts within a frame, and the own multi-target chip address
	localparam logic [5:0] LG_RW_EDGE = 6'h01;
	localparam logic [5:0] LG_ADDR_LAST = 6'h07;
	localparam logic [5:0] LG_DATA_FIRST = 6'h08;
	localparam logic [5:0] LG_DATA_LAST = 6'h1F;
	localparam logic [5:0] LG_COMMIT = 6'h20;
	localparam logic [5:0] MT_FRAME_BITS = 6'h20;
	localparam logic [2:0] MT_CHIP_SELF = 3'h0;

endpackage : pspg_pkg

// File: core/pspg_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pspg_sync (
	input wire logic clk,
	input wire logic srst,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
	logic nxt_lvl;

	always_comb begin
		nxt_lvl = lvl_ff;
		// Only a settled sample counts, so a metastable glitch never makes an edge
		if (s2_ff == s3_ff) begin
			nxt_lvl = s3_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			lvl_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			lvl_ff <= nxt_lvl;
			rise_ff <= nxt_lvl & ~lvl_ff;
			fall_ff <= ~nxt_lvl & lvl_ff;
		end
	end

	assign level = lvl_ff;
	assign rise = rise_ff;
	assign fall = fall_ff;
endmodule : pspg_sync

// File: core/pspg_pin_drv.sv
// Shared output pin source mux and tri-state enable logic
`timescale 1ns/100ps
module pspg_pin_drv (
	input wire logic clk,
	input wire logic srst,
	input wire logic read_active,
	input wire logic read_drive,
	input wire logic read_bit,
	input wire logic gpo_bit,
	input wire logic master_en,
	input wire logic oe_hold,
	input wire logic src_hold,
	input wire logic chip_gate,
	input wire logic chip_en,
	input wire logic up_off,
	input wire logic dn_off,
	output logic pin_out,
	output logic pin_oe_n
);
	logic out_ff, oe_n_ff;
	logic nxt_out, nxt_oe_n, drive, half_ok;

	always_comb begin
		nxt_out = (read_active && !src_hold) ? read_bit : gpo_bit;
		drive = master_en && (oe_hold || read_drive);
		drive = drive && (!chip_gate || chip_en);
		half_ok = nxt_out ? !up_off : !dn_off;
		nxt_oe_n = !(drive && half_ok);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			out_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			out_ff <= nxt_out;
			oe_n_ff <= nxt_oe_n;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe_n = oe_n_ff;

	master_off_a: assert property (@(posedge clk) disable iff (srst)
		!master_en |=> pin_oe_n) else $error("driver on while master disabled");
	hold_drives_a: assert property (@(posedge clk) disable iff (srst)
		(master_en && oe_hold && !chip_gate && !up_off && !dn_off) |=> !pin_oe_n)
		else $error("hold bit did not keep driver on");
	gpo_source_a: assert property (@(posedge clk) disable iff (srst)
		(src_hold || !read_active) |=> pin_out == $past(gpo_bit))
		else $error("general signal not routed to pin");
endmodule : pspg_pin_drv

// File: sim/pspg_host.sv
// Host serial master model: frames both protocols and samples the shared pin
`timescale 1ns/100ps
module pspg_host (
	output logic sck,
	output logic frame_select,
	output logic sdi,
	input wire logic pin_o,
	input wire logic pin_oe_n
);
	logic [31:0] rx;
	logic [31:0] oen;

	initial begin
		sck = 1'b0;
		frame_select = 1'b0;
		sdi = 1'b0;
		rx = 32'h0;
		oen = 32'h0;
	end

	// Pin settles several core cycles after a rise, so look just before the next rise
	task automatic grab();
		rx = {rx[30:0], pin_o};
		oen = {oen[30:0], pin_oe_n};
	endtask : grab

	// Clock stands low outside frames; released data line shows the inverse level
	task automatic shift32(input logic [31:0] word);
		for (int i = 31; i >= 0; i--) begin
			sdi = word[i];
			#80;
			grab();
			sck = 1'b1;
			#80;
			sck = 1'b0;
		end
		#80;
		sdi = ~sdi;
		#80;
		grab();
	endtask : shift32

	task automatic legacy(input logic [31:0] word);
		frame_select = 1'b1;
		#80;
		shift32(word);
		frame_select = 1'b0;
		#320;
	endtask : legacy

	task automatic multi(input logic [31:0] word);
		shift32(word);
		frame_select = 1'b1;
		#160;
		frame_select = 1'b0;
		#160;
	endtask : multi
endmodule : pspg_host

// File: sim/tb.sv
// Self-checking bench for the serial port and shared output pin block
`timescale 1ns/100ps
module tb;
	localparam logic [23:0] VER = 24'h3C5A96; // Arbitrary value
	localparam int WATCHDOG_NS = 600000;
	logic core_clk;
	logic srst;
	logic chip_en;
	logic [31:0] gen_src;
	logic sck;
	logic frame_select;
	logic sdi;
	logic pin_o;
	logic pin_oe_n;
	logic [1:0] mode;
	logic wr_pulse;
	logic [5:0] wr_addr;
	logic [23:0] wr_data;
	logic [17:0] strobes;
	logic [17:0] strobe_seen;
	logic [31:0] seed;
	logic [23:0] d;
	logic [5:0] a;
	logic [4:0] sel;
	int n_fail;
	int n_checks;
	int n_wr;

	pspg_top #(.VERSION_CODE(VER)) i_dut (
		.CORE_CLK(core_clk),
		.SRST(srst),
		.SCK_PIN(sck),
		.FRAME_SELECT(frame_select),
		.SDI_PIN(sdi),
		.CHIP_EN(chip_en),
		.GENERAL_OUTPUT_SOURCES(gen_src),
		.LOCK_DETECT_SERIAL_OUT_PIN_O(pin_o),
		.LOCK_DETECT_SERIAL_OUT_PIN_OE_N(pin_oe_n),
		.PROTOCOL_MODE(mode),
		.REG_WR_PULSE(wr_pulse),
		.REG_WR_ADDR(wr_addr),
		.REG_WR_DATA(wr_data),
		.GEN_STROBES(strobes)
	);

	pspg_host i_host (
		.sck(sck),
		.frame_select(frame_select),
		.sdi(sdi),
		.pin_o(pin_o),
		.pin_oe_n(pin_oe_n)
	);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Strobes last one cycle, so keep the last burst for later comparison
	always @(posedge core_clk) begin
		if (strobes != 18'h0) strobe_seen <= strobes;
		if (wr_pulse === 1'b1) n_wr++;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	function automatic logic [31:0] lg_word(input logic rd, input logic [5:0] ad,
		input logic [23:0] dt);
		return {rd, ad, dt, 1'b0};
	endfunction : lg_word

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reset_dut();
		srst = 1'b1;
		repeat (20) @(posedge core_clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask : reset_dut

	task automatic settle();
		repeat (8) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic lw(input logic [5:0] ad, input logic [23:0] dt);
		i_host.legacy(lg_word(1'b0, ad, dt));
	endtask : lw

	task automatic lr(input logic [5:0] ad);
		i_host.legacy(lg_word(1'b1, ad, 24'h0));
	endtask : lr

	initial begin
		#(WATCHDOG_NS);
		n_fail++;
		$display("CHECK FAILED watchdog expected done seen hang");
		tally_and_finish();
	end

	initial begin
		srst = 1'b1;
		chip_en = 1'b1;
		gen_src = 32'h0;
		seed = 32'h51;
		strobe_seen = 18'h0;
		n_fail = 0;
		n_checks = 0;
		n_wr = 0;
		reset_dut();
		chk("mode idle", 32'h0, 32'(mode));
		chk("pin off", 32'h1, 32'(pin_oe_n));
		seed = xorshift(seed);
		gen_src = seed;
		lr(pspg_pkg::REG_VERSION);
		chk("mode legacy", 32'(pspg_pkg::PSPG_LEGACY), 32'(mode));
		chk("version", 32'(VER), 32'(i_host.rx[24:1]));
		chk("read enable", 32'hFE000001, i_host.oen);
		chk("lock restored", 32'(gen_src[1]), 32'(i_host.rx[0]));
		chk("lock idle", 32'(gen_src[1]), 32'(pin_o));
		for (int k = 0; k < 4; k++) begin
			seed = xorshift(seed);
			a = (k == 0) ? 6'h3F : {1'b1, seed[4:0]};
			d = (k == 0) ? 24'hFFFFFF : seed[31:8];
			lw(a, d);
			chk("write addr", 32'(a), 32'(wr_addr));
			chk("write data", 32'(d), 32'(wr_data));
			chk("write quiet", 32'hFFFFFFFF, i_host.oen);
			lr(a);
			chk("readback", 32'(d), 32'(i_host.rx[24:1]));
			chk("read no write", 32'(d), 32'(wr_data));
		end
		chk("write pulses", 32'd4, 32'(n_wr));
		$display("test legacy frames done");
		for (int k = 0; k < 3; k++) begin
			seed = xorshift(seed);
			sel = seed[4:0];
			gen_src = xorshift(seed);
			lw(pspg_pkg::REG_PIN_CFG, {16'h0, 3'b100, sel});
			settle();
			chk("hold drive", 32'h0, 32'(pin_oe_n));
			chk("source pick", 32'(gen_src[sel]), 32'(pin_o));
		end
		lw(pspg_pkg::REG_PIN_CFG, 24'h000181);
		gen_src = 32'h2;
		settle();
		chk("up half off", 32'h1, 32'(pin_oe_n));
		gen_src = 32'h0;
		settle();
		chk("low still driven", 32'h0, 32'(pin_oe_n));
		lw(pspg_pkg::REG_PIN_CFG, 24'h000281);
		settle();
		chk("down half off", 32'h1, 32'(pin_oe_n));
		lw(pspg_pkg::REG_PIN_CFG, 24'h000081);
		lw(pspg_pkg::REG_DRV_CTRL, 24'h0);
		settle();
		chk("master off", 32'h1, 32'(pin_oe_n));
		lw(pspg_pkg::REG_DRV_CTRL, pspg_pkg::RST_DRV_CTRL);
		chip_en = 1'b0;
		settle();
		chk("chip gated", 32'h1, 32'(pin_oe_n));
		lw(pspg_pkg::REG_CHIP_CTRL, 24'h0);
		settle();
		chk("chip ungated", 32'h0, 32'(pin_oe_n));
		chip_en = 1'b1;
		gen_src = 32'h2;
		lw(pspg_pkg::REG_PIN_CFG, 24'h0000C1);
		lr(pspg_pkg::REG_VERSION);
		chk("source held", 32'hFFFFFF, 32'(i_host.rx[24:1]));
		lw(pspg_pkg::REG_PIN_CFG, 24'h000081);
		lr(pspg_pkg::REG_VERSION);
		chk("automux", 32'(VER), 32'(i_host.rx[24:1]));
		chk("always on", 32'h0, i_host.oen);
		lw(pspg_pkg::REG_VERSION, {18'h2B3C5, 1'b1, 5'h0});
		settle();
		chk("strobes", 32'h2B3C5, 32'(strobe_seen));
		chk("mode kept", 32'(pspg_pkg::PSPG_LEGACY), 32'(mode));
		chk("defaults back", 32'h1, 32'(pin_oe_n));
		$display("test pin control done");
		reset_dut();
		i_host.multi({24'h00000F, 5'h00, 3'h0});
		chk("mode multi", 32'(pspg_pkg::PSPG_MULTI), 32'(mode));
		chk("multi addr", 32'h0, 32'(wr_addr));
		chk("multi data", 32'h0F, 32'(wr_data));
		seed = xorshift(seed);
		d = seed[23:0];
		i_host.multi({d, 5'h12, 3'h0});
		chk("portion data", 32'(pspg_pkg::RST_PIN_CFG), 32'(i_host.rx[31:8]));
		chk("addressed drive", 32'h0, 32'(i_host.oen[0]));
		chk("portion end", 32'h1, 32'(pin_oe_n));
		i_host.multi({24'h000012, 5'h00, 3'h0});
		seed = xorshift(seed);
		i_host.multi({seed[23:0], 5'h13, 3'b101});
		chk("new read addr", 32'(d), 32'(i_host.rx[31:8]));
		chk("other chip", 32'h1, 32'(i_host.oen[0]));
		chk("frame dropped", 32'h0, 32'(wr_addr));
		chk("all write pulses", 32'd19, 32'(n_wr));
		$display("test multi target done");
		tally_and_finish();
	end
endmodule : tb
